// File: shared/qsc_pkg.sv
/*
  shared constants and carriers of the quad mode / status control block.
  assumes a 25 MHz system clock and an spi host on the quad_io_lines.
*/
package qsc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_UNIT_NS = 1000;
  localparam int WAKE_COUNT = 2;
  localparam int WAKE_TIME_NS = (WAKE_COUNT + 1) * WAKE_UNIT_NS;
  localparam logic [15:0] WAKE_CYCLES = 16'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int STATUS_WRITE_TIME_NS = 5000;
  localparam logic [15:0] STATUS_WRITE_CYCLES = 16'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] OP_CYCLES_RESET = 16'h00FA;

  localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
  localparam logic [7:0] OP_READ_STATUS2 = 8'h35;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_READ_PARAM = 8'h5A;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [3:0] MODE_KEEP_NIBBLE = 4'hA;
  localparam logic [7:0] MODE_ENTRY = 8'hA5;
  localparam logic [7:0] MODE_EXIT = 8'h00;
  localparam logic [31:0] RESET_PATTERN = 32'hFFFFFFFF;
  localparam int QUAD_IO_ENABLE_POS = 1;

  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] CMD_DONE = 6'h08;
  localparam logic [5:0] WRSR_DONE = 6'h10;
  localparam logic [5:0] PADDR_LAST = 6'h17;
  localparam logic [5:0] PDUMMY_LAST = 6'h07;
  localparam logic [5:0] QADDR_LAST = 6'h07;
  localparam logic [5:0] QDUMMY_LAST = 6'h03;

  localparam logic [7:0] STATUS1_RESET = 8'h00;
  localparam logic [7:0] STATUS2_RESET = 8'h00;
  localparam logic [5:0] SYNC_IDLE = 6'h20;

  localparam logic [7:0] PARAM_D14_ADDR = 8'h34;
  localparam logic [31:0] PARAM_DWORD14 = 32'h5CD5A2F7;
  localparam logic [7:0] PARAM_D15_ADDR = 8'h38;
  localparam logic [31:0] PARAM_DWORD15 = 32'hFF59F600;
  localparam logic [7:0] RESERVED_FIELD_FILL = 8'hFF;

  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_OP_CYCLES = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;

  typedef enum logic [3:0] {
    PH_IDLE, PH_CMD, PH_WRSR, PH_PADDR, PH_PDUMMY, PH_POUT,
    PH_SOUT, PH_QADDR, PH_QDUMMY, PH_QOUT, PH_IGNORE
  } qsc_phase_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } qsc_avm_req_type;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } qsc_pins_type;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] filt;
    logic [5:0] filt_q;
    qsc_phase_type phase;
    logic [5:0] cnt;
    logic [31:0] shin;
    logic [7:0] shout;
    logic [7:0] status1;
    logic [7:0] status2;
    logic powered_down;
    logic [15:0] wake_cnt;
    logic [15:0] busy_cnt;
    logic continuous;
    logic cont_pending;
    logic [15:0] op_cycles;
    logic [7:0] param_addr;
    qsc_pins_type pins;
    logic ack;
    logic [31:0] readdata;
  } qsc_state_type;
endpackage

// File: verification/qsc_spi_host.sv
/*
  spi host model: drives sclk, cs_n and the quad io lines, reads line 1.
  assumes sys_clk at 25 MHz; one sclk period is eight sys_clk cycles, mode 0.
*/
`timescale 1ns/1ps
module qsc_spi_host (
  input wire logic sys_clk,
  input wire logic [3:0] lines,
  input wire logic [3:0] dev_oe,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] host_io,
  output logic drove
);
  logic [3:0] val;
  logic [3:0] oe;
  logic [3:0] fl;
  logic cs_q;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    cs_q = 1'b1;
    val = 4'h0;
    oe = 4'h0;
    fl = 4'h5;
    drove = 1'b0;
  end
  // released lines toggle so a stale level never passes for data
  assign host_io = (oe & val) | (~oe & fl);
  // drove: device drove a line since the last frame start
  always @(posedge sys_clk) begin
    fl <= ~fl;
    cs_q <= cs_n;
    if (cs_q && !cs_n) begin
      drove <= 1'b0;
    end else if (|dev_oe) begin
      drove <= 1'b1;
    end
  end
  // one sclk period; lines read late in the high half
  task automatic clock(input logic [3:0] o, input logic [3:0] v, output logic [3:0] seen);
    @(posedge sys_clk);
    sclk <= 1'b0;
    oe <= o;
    val <= v;
    repeat (4) @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    seen = lines;
  endtask
  task automatic start();
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // sclk stands still low outside frames
  task automatic stop();
    @(posedge sys_clk);
    sclk <= 1'b0;
    oe <= 4'h0;
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [3:0] s;
    for (int i = 7; i >= 0; i--) clock(4'h1, {3'b000, b[i]}, s);
  endtask
  task automatic recv_byte(output logic [7:0] b);
    logic [3:0] s;
    for (int i = 7; i >= 0; i--) begin
      clock(4'h0, 4'h0, s);
      b[i] = s[1];
    end
  endtask
endmodule

// File: verification/test_quad_mode_status_control.sv
/*
  self-checking bench of the quad mode / status control block.
  assumes the package and the spi host model are compiled first.
*/
`timescale 1ns/1ps
module test_quad_mode_status_control;
  import qsc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  qsc_avm_req_type avm_req = '0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic sclk;
  logic cs_n;
  logic drove;
  logic [3:0] host_io;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [3:0] lines;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  logic [31:0] q;
  logic [7:0] b;
  logic [3:0] s;
  always #20 sys_clk = ~sys_clk;
  assign lines = (dev_oe & dev_out) | (~dev_oe & host_io);
  qsc_quad_mode_status_control u_dut (.sys_clk(sys_clk), .reset(reset), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .sclk_in(sclk), .cs_n_in(cs_n),
    .quad_io_lines_in(lines), .quad_io_lines_out(dev_out), .quad_io_lines_oe(dev_oe));
  qsc_spi_host u_host (.sys_clk(sys_clk), .lines(lines), .dev_oe(dev_oe), .sclk(sclk), .cs_n(cs_n),
    .host_io(host_io), .drove(drove));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge sys_clk);
    avm_req <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge sys_clk);
      k++;
    end while (avm_waitrequest !== 1'b0 && k < 50);
    rd = avm_readdata;
    avm_req <= '0;
    check("bus answer", 32'h0000_0000, {31'h0, avm_waitrequest});
  endtask
  function automatic logic [31:0] st(logic [7:0] s1, logic [7:0] s2, logic bz, logic wk, logic pd, logic ct);
    return {12'h000, ct, pd, wk, bz, s2, s1};
  endfunction
  task automatic spi_status(input logic [7:0] op, output logic [7:0] v);
    u_host.start();
    u_host.send_byte(op);
    u_host.recv_byte(v);
    u_host.stop();
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.start();
    u_host.send_byte(op);
    u_host.stop();
  endtask
  task automatic wrsr(input logic [7:0] s1, input logic [7:0] s2);
    u_host.start();
    u_host.send_byte(OP_WRITE_STATUS);
    u_host.send_byte(s1);
    u_host.send_byte(s2);
    u_host.stop();
  endtask
  task automatic quad_read(input logic cont, input logic [7:0] mode, output logic [3:0] x);
    u_host.start();
    if (!cont) u_host.send_byte(OP_QUAD_IO_READ);
    repeat (6) u_host.clock(4'hF, 4'h0, x);
    u_host.clock(4'hF, mode[7:4], x);
    u_host.clock(4'hF, mode[3:0], x);
    repeat (6) u_host.clock(4'h0, 4'h0, x);
    u_host.stop();
  endtask
  task automatic param(input logic [7:0] a, output logic [31:0] d);
    logic [3:0] x;
    logic [7:0] v;
    u_host.start();
    u_host.send_byte(OP_READ_PARAM);
    u_host.send_byte(8'h00);
    u_host.send_byte(8'h00);
    u_host.send_byte(a);
    repeat (8) u_host.clock(4'h0, 4'h0, x);
    for (int i = 0; i < 4; i++) begin
      u_host.recv_byte(v);
      d[8*i +: 8] = v;
    end
    u_host.stop();
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("state after reset", 32'h0000_0000, q);
    bus(1'b0, REG_OP_CYCLES, 32'h0, q);
    check("op cycles after reset", 32'h0000_00FA, q);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    bus(1'b0, 4'hC, 32'h0, q);
    check("unmapped read", 32'h0000_0000, q);
    $display("test reset_values done");
    quad_read(1'b0, MODE_ENTRY, s);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("continuous without quad enable", 32'h0000_0000, q);
    spi_status(OP_READ_STATUS2, b);
    check("status2 before write", 32'h0000_0000, {24'h0, b});
    wrsr(8'h00, 8'h02);
    repeat (90) @(posedge sys_clk);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("busy during status write", st(8'h01, 8'h02, 1'b1, 1'b0, 1'b0, 1'b0), q);
    repeat (30) @(posedge sys_clk);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("busy after status write", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0), q);
    spi_status(OP_READ_STATUS1, b);
    check("status1 ready", 32'h0000_0000, {24'h0, b});
    spi_status(OP_READ_STATUS2, b);
    check("status2 quad enable", 32'h0000_0002, {24'h0, b});
    $display("test status_quad_enable done");
    bus(1'b1, REG_OP_CYCLES, 32'h0000_0400, q);
    bus(1'b1, REG_CONTROL, 32'h0000_0001, q);
    spi_status(OP_READ_STATUS1, b);
    check("status1 busy", 32'h0000_0001, {24'h0, b});
    wrsr(8'h00, 8'h00);
    n = 0;
    while (b[0] !== 1'b0 && n < 12) begin
      spi_status(OP_READ_STATUS1, b);
      n++;
    end
    check("busy polled clear", 32'h0000_0000, {24'h0, b});
    bus(1'b0, REG_STATE, 32'h0, q);
    check("status write refused while busy", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0), q);
    $display("test busy_polling done");
    param(PARAM_D14_ADDR, q);
    check("dword 14", 32'h5CD5_A2F7, q);
    param(PARAM_D15_ADDR, q);
    check("dword 15", 32'hFF59_F600, q);
    $display("test parameter_table done");
    cmd(OP_POWER_DOWN);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("powered down", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0), q);
    spi_status(OP_READ_STATUS2, b);
    check("silent while powered down", 32'h0000_0000, {31'h0, drove});
    cmd(OP_WAKE);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("wake delay running", 32'h0000_0001, {31'h0, q[17]});
    repeat (45) @(posedge sys_clk);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("wake delay still running", 32'h0000_0001, {31'h0, q[17]});
    repeat (20) @(posedge sys_clk);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("ready after wake", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0), q);
    $display("test power_down done");
    quad_read(1'b0, MODE_ENTRY, s);
    check("quad data", 32'h0000_000F, {28'h0, s});
    bus(1'b0, REG_STATE, 32'h0, q);
    check("continuous entered", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b1), q);
    quad_read(1'b1, MODE_EXIT, s);
    check("last read before exit", 32'h0000_000F, {28'h0, s});
    bus(1'b0, REG_STATE, 32'h0, q);
    check("continuous left", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0), q);
    quad_read(1'b0, MODE_ENTRY, s);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("continuous before reset pattern", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b1), q);
    u_host.start();
    repeat (8) u_host.clock(4'hF, 4'hF, s);
    u_host.stop();
    bus(1'b0, REG_STATE, 32'h0, q);
    check("continuous reset pattern", st(8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0), q);
    $display("test continuous_read done");
    spi_status(OP_QPI_ENTER, b);
    check("all-quad command ignored", 32'h0000_0000, {31'h0, drove});
    wrsr(8'h00, 8'h00);
    repeat (140) @(posedge sys_clk);
    spi_status(OP_READ_STATUS2, b);
    check("quad enable cleared", 32'h0000_0000, {24'h0, b});
    quad_read(1'b0, MODE_ENTRY, s);
    bus(1'b0, REG_STATE, 32'h0, q);
    check("continuous refused after clear", st(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0), q);
    $display("test quad_enable_clear done");
    results();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    $display("mismatch watchdog expected finish seen timeout");
    results();
  end
endmodule

// File: verilog/qsc_param_rom.sv
/*
  parameter table rom: two parameter dwords, all else reads as fill.
  assumes addr is stable for a cycle before data is used.
*/
`timescale 1ns/1ps
module qsc_param_rom
  import qsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  logic [7:0] next_data;

  always_comb begin
    next_data = RESERVED_FIELD_FILL;
    for (int i = 0; i < 4; i++) begin
      if (addr == PARAM_D14_ADDR + 8'(i)) begin
        next_data = PARAM_DWORD14[8*i +: 8];
      end
      if (addr == PARAM_D15_ADDR + 8'(i)) begin
        next_data = PARAM_DWORD15[8*i +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data <= RESERVED_FIELD_FILL;
    end else begin
      data <= next_data;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_D14_TOP: assert property (addr == 8'h37 |=> data == 8'h5C) else $error("dword 14 top byte wrong");
  AST_D14_LOW: assert property (addr == 8'h34 |=> data[7:4] == 4'hF && data[1:0] == 2'h3)
    else $error("dword 14 reserved bits not ones");
  AST_D15_TOP: assert property (addr == 8'h3B |=> data == 8'hFF) else $error("dword 15 top byte not ones");
  AST_HOLD_WP: assert property (addr == 8'h3A |=> !data[7]) else $error("hold disable flagged");
  AST_QUAD_SUP: assert property (addr == 8'h39 |=> data[1]) else $error("quad read support flag low");
  AST_NO_444: assert property (addr == 8'h38 |=> data == 8'h00) else $error("4-4-4 sequences flagged");
endmodule

// File: verilog/qsc_quad_mode_status_control.sv
/*
  spi flash command logic: status, quad enable, power down, continuous quad read.
  assumes sclk, cs_n and quad_io_lines come from outside this clock domain,
  with sclk slow enough for eight or more sys_clk cycles per period.
*/
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module qsc_quad_mode_status_control
  import qsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire qsc_avm_req_type avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] quad_io_lines_in,
  output logic [3:0] quad_io_lines_out,
  output logic [3:0] quad_io_lines_oe
);
  qsc_state_type r;
  qsc_state_type s;
  logic [7:0] rom_data;
  logic write_in_progress_flag;
  logic quad_io_enable_bit;
  logic waking;
  logic [7:0] status1_byte;
  logic [7:0] cmd_byte;
  logic [31:0] quad_word;
  logic [7:0] out_byte;
  logic cs_n;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  // next phase after an opcode, given power and busy state
  function automatic qsc_phase_type cmd_phase(input logic [7:0] op, input logic pd,
                                              input logic wk, input logic bsy, input logic qen);
    qsc_phase_type ph;
    ph = PH_IGNORE;
    if (wk) begin
      ph = PH_IGNORE;
    end else if (pd) begin
      ph = (op == OP_WAKE) ? PH_CMD : PH_IGNORE;
    end else begin
      case (op)
        OP_READ_STATUS1, OP_READ_STATUS2: ph = PH_SOUT;
        OP_WRITE_STATUS: ph = bsy ? PH_IGNORE : PH_WRSR;
        OP_READ_PARAM: ph = bsy ? PH_IGNORE : PH_PADDR;
        OP_QUAD_IO_READ: ph = (qen && !bsy) ? PH_QADDR : PH_IGNORE;
        OP_POWER_DOWN: ph = bsy ? PH_IGNORE : PH_CMD;
        default: ph = PH_IGNORE;
      endcase
    end
    return ph;
  endfunction

  qsc_param_rom u_rom (
    .sys_clk(sys_clk),
    .reset(reset),
    .addr(r.param_addr),
    .data(rom_data)
  );

  assign write_in_progress_flag = r.busy_cnt != 16'h0000;
  assign quad_io_enable_bit = r.status2[QUAD_IO_ENABLE_POS];
  assign waking = r.wake_cnt != 16'h0000;
  assign status1_byte = {r.status1[7:1], write_in_progress_flag};
  assign cs_n = r.filt[5];
  assign rise = r.filt[4] & ~r.filt_q[4] & ~cs_n;
  assign fall = ~r.filt[4] & r.filt_q[4] & ~cs_n;
  assign cs_fall = ~cs_n & r.filt_q[5];
  assign cs_rise = cs_n & ~r.filt_q[5];
  assign cmd_byte = {r.shin[6:0], r.filt[0]};
  assign quad_word = {r.shin[27:0], r.filt[3:0]};
  assign out_byte = (r.phase == PH_POUT) ? rom_data :
                    (r.shin[7:0] == OP_READ_STATUS2) ? r.status2 : status1_byte;

  assign avm_waitrequest = (avm_req.read | avm_req.write) & ~r.ack;
  assign avm_readdata = r.readdata;
  assign quad_io_lines_out = r.pins.out;
  assign quad_io_lines_oe = r.pins.oe;

  always_comb begin
    s = r;
    // three-stage input sampling, a change counts when stages two and three agree
    s.sync1 = {cs_n_in, sclk_in, quad_io_lines_in};
    s.sync2 = r.sync1;
    s.sync3 = r.sync2;
    s.filt_q = r.filt;
    for (int i = 0; i < 6; i++) begin
      if (r.sync2[i] == r.sync3[i]) begin
        s.filt[i] = r.sync3[i];
      end
    end

    // timers
    if (waking) begin
      s.wake_cnt = r.wake_cnt - 16'h0001;
    end
    if (write_in_progress_flag) begin
      s.busy_cnt = r.busy_cnt - 16'h0001;
    end

    // register bus, answered one cycle after the request
    s.ack = (avm_req.read | avm_req.write) & ~r.ack;
    if (avm_req.read && !r.ack) begin
      unique case (avm_req.address)
        REG_OP_CYCLES: s.readdata = {16'h0000, r.op_cycles};
        REG_STATE: s.readdata = {12'h000, r.continuous, r.powered_down, waking,
                                 write_in_progress_flag, r.status2, status1_byte};
        default: s.readdata = 32'h00000000;
      endcase
    end
    if (avm_req.write && r.ack) begin
      if (avm_req.address == REG_CONTROL && avm_req.writedata[0] && !write_in_progress_flag) begin
        s.busy_cnt = r.op_cycles;
      end
      if (avm_req.address == REG_OP_CYCLES) begin
        s.op_cycles = avm_req.writedata[15:0];
      end
    end

    // spi frame handling
    if (cs_fall) begin
      s.phase = r.continuous ? PH_QADDR : PH_CMD;
      s.cnt = 6'h00;
    end else if (cs_rise) begin
      if (r.phase == PH_CMD && r.cnt == CMD_DONE) begin
        if (r.shin[7:0] == OP_POWER_DOWN) begin
          s.powered_down = 1'b1;
        end else if (r.shin[7:0] == OP_WAKE) begin
          s.powered_down = 1'b0;
          s.wake_cnt = WAKE_CYCLES;
        end
      end
      if (r.phase == PH_WRSR && r.cnt == WRSR_DONE) begin
        s.status1 = {r.shin[15:10], r.status1[1:0]};
        s.status2 = r.shin[7:0];
        s.busy_cnt = STATUS_WRITE_CYCLES;
      end
      if (r.phase == PH_QDUMMY || r.phase == PH_QOUT) begin
        s.continuous = r.cont_pending;
      end
      s.phase = PH_IDLE;
      s.pins.oe = 4'h0;
    end else if (rise) begin
      unique case (r.phase)
        PH_CMD: begin
          if (r.cnt == CMD_DONE) begin
            s.phase = PH_IGNORE;
          end else begin
            s.shin = {r.shin[30:0], r.filt[0]};
            s.cnt = r.cnt + 6'h01;
            if (r.cnt == CMD_LAST) begin
              s.phase = cmd_phase(cmd_byte, r.powered_down, waking,
                                  write_in_progress_flag, quad_io_enable_bit);
              if (s.phase != PH_CMD) begin
                s.cnt = 6'h00;
              end
            end
          end
        end
        PH_WRSR: begin
          if (r.cnt == WRSR_DONE) begin
            s.phase = PH_IGNORE;
          end else begin
            s.shin = {r.shin[30:0], r.filt[0]};
            s.cnt = r.cnt + 6'h01;
          end
        end
        PH_PADDR: begin
          s.shin = {r.shin[30:0], r.filt[0]};
          s.cnt = r.cnt + 6'h01;
          if (r.cnt == PADDR_LAST) begin
            s.param_addr = cmd_byte;
            s.phase = PH_PDUMMY;
            s.cnt = 6'h00;
          end
        end
        PH_PDUMMY: begin
          s.cnt = r.cnt + 6'h01;
          if (r.cnt == PDUMMY_LAST) begin
            s.phase = PH_POUT;
            s.cnt = 6'h00;
          end
        end
        PH_SOUT, PH_POUT: begin
          s.cnt = r.cnt + 6'h01;
          if (r.phase == PH_POUT && r.cnt[2:0] == 3'h7) begin
            s.param_addr = r.param_addr + 8'h01;
          end
        end
        PH_QADDR: begin
          s.shin = quad_word;
          s.cnt = r.cnt + 6'h01;
          if (r.cnt == QADDR_LAST) begin
            if (r.continuous && quad_word == RESET_PATTERN) begin
              s.continuous = 1'b0;
              s.phase = PH_IGNORE;
            end else begin
              s.cont_pending = quad_io_enable_bit && quad_word[7:4] == MODE_KEEP_NIBBLE;
              s.phase = PH_QDUMMY;
              s.cnt = 6'h00;
            end
          end
        end
        PH_QDUMMY: begin
          s.cnt = r.cnt + 6'h01;
          if (r.cnt == QDUMMY_LAST) begin
            s.phase = PH_QOUT;
          end
        end
        PH_IDLE, PH_QOUT, PH_IGNORE: begin
        end
      endcase
    end else if (fall) begin
      if (r.phase == PH_SOUT || r.phase == PH_POUT) begin
        if (r.cnt[2:0] == 3'h0) begin
          s.shout = out_byte;
        end else begin
          s.shout = {r.shout[6:0], 1'b0};
        end
        s.pins.out = {2'h0, s.shout[7], 1'b0};
        s.pins.oe = 4'h2;
      end else if (r.phase == PH_QOUT) begin
        // array contents are outside this block: erased data
        s.pins.out = 4'hF;
        s.pins.oe = 4'hF;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.sync1 <= SYNC_IDLE;
      r.sync2 <= SYNC_IDLE;
      r.sync3 <= SYNC_IDLE;
      r.filt <= SYNC_IDLE;
      r.filt_q <= SYNC_IDLE;
      r.status1 <= STATUS1_RESET;
      r.status2 <= STATUS2_RESET;
      r.op_cycles <= OP_CYCLES_RESET;
    end else begin
      r <= s;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // power down and wake
  AST_WAKE_LOAD: assert property ($fell(r.powered_down) |-> r.wake_cnt == WAKE_CYCLES)
    else $error("wake delay not loaded");
  AST_WAKE_COUNT: assert property (waking |=> r.wake_cnt == $past(r.wake_cnt) - 16'h0001)
    else $error("wake delay not counting");
  AST_WAKE_IGNORE: assert property (rise && r.phase == PH_CMD && r.cnt == CMD_LAST && waking
    |=> r.phase == PH_IGNORE) else $error("command taken during wake delay");
  AST_POWER_DOWN: assert property (cs_rise && r.phase == PH_CMD && r.cnt == CMD_DONE
    && r.shin[7:0] == OP_POWER_DOWN |=> r.powered_down) else $error("power down not entered");
  AST_PD_REFUSE: assert property (rise && r.phase == PH_CMD && r.cnt == CMD_LAST
    && r.powered_down && cmd_byte != OP_WAKE |=> r.phase == PH_IGNORE) else $error("command taken while powered down");
  AST_WAKE_UP: assert property (cs_rise && r.phase == PH_CMD && r.cnt == CMD_DONE
    && r.shin[7:0] == OP_WAKE |=> !r.powered_down && waking) else $error("wake command not applied");
  AST_IGNORE_SILENT: assert property (r.phase == PH_IGNORE || r.phase == PH_IDLE |-> r.pins.oe == 4'h0)
    else $error("lines driven outside an output phase");
  AST_OE_CS: assert property (cs_rise |=> r.pins.oe == 4'h0)
    else $error("lines still driven after frame end");

  // status registers and busy
  AST_BUSY_READ: assert property (fall && r.phase == PH_SOUT && r.cnt[2:0] == 3'h0
    && r.shin[7:0] == OP_READ_STATUS1 |=> r.shout[0] == $past(write_in_progress_flag))
    else $error("busy bit not reported");
  AST_SOUT_LINE: assert property (fall && r.phase == PH_SOUT |=> r.pins.oe == 4'h2)
    else $error("status not on line one");
  AST_QE_READ: assert property (fall && r.phase == PH_SOUT && r.cnt[2:0] == 3'h0
    && r.shin[7:0] == OP_READ_STATUS2 |=> r.shout == $past(r.status2)
    ##1 r.pins.oe == 4'h2) else $error("status two not returned");
  AST_QE_WRITE: assert property (cs_rise && r.phase == PH_WRSR && r.cnt == WRSR_DONE
    |=> quad_io_enable_bit == $past(r.shin[1]) && r.busy_cnt == STATUS_WRITE_CYCLES)
    else $error("status write not applied");
  AST_WRSR_BUSY: assert property (rise && r.phase == PH_CMD && r.cnt == CMD_LAST && !waking
    && !r.powered_down && write_in_progress_flag && cmd_byte == OP_WRITE_STATUS |=> r.phase == PH_IGNORE)
    else $error("status write taken while busy");
  AST_BUSY_HOLD: assert property (r.busy_cnt > 16'h0008 |-> write_in_progress_flag[*8])
    else $error("busy dropped early");
  AST_CTRL_START: assert property (avm_req.write && r.ack && avm_req.address == REG_CONTROL
    && avm_req.writedata[0] && !write_in_progress_flag && !cs_rise |=> r.busy_cnt == $past(r.op_cycles))
    else $error("internal cycle not started");
  AST_PARAM_ADDR: assert property (rise && r.phase == PH_POUT && r.cnt[2:0] == 3'h7
    |=> r.param_addr == $past(r.param_addr) + 8'h01) else $error("parameter address not advanced");

  // continuous quad read
  AST_ENTRY_NEEDS_QE: assert property (rise && r.phase == PH_CMD && r.cnt == CMD_LAST
    && cmd_byte == OP_QUAD_IO_READ && !quad_io_enable_bit |=> r.phase == PH_IGNORE)
    else $error("quad read taken without enable");
  AST_CONT_ENTRY: assert property (cs_rise && r.phase == PH_QOUT && r.cont_pending |=> r.continuous)
    else $error("continuous mode not entered");
  AST_CONT_QE: assert property ($rose(r.continuous) |-> quad_io_enable_bit)
    else $error("continuous mode without quad enable");
  AST_CONT_FRAME: assert property (cs_fall && r.continuous |=> r.phase == PH_QADDR)
    else $error("continuous frame expected an opcode");
  AST_QUAD_DRIVE: assert property (fall && r.phase == PH_QOUT |=> r.pins.oe == 4'hF)
    else $error("quad data not driven");
  AST_EXIT_BYTE: assert property (rise && r.phase == PH_QADDR && r.cnt == QADDR_LAST
    && quad_word[7:0] == MODE_EXIT |=> !r.cont_pending) else $error("exit mode byte kept continuous");
  AST_MODE_EXIT: assert property (cs_rise && r.phase == PH_QOUT && !r.cont_pending
    |=> !r.continuous) else $error("continuous mode not left");
  AST_RESET_PATTERN: assert property (rise && r.phase == PH_QADDR && r.cnt == QADDR_LAST
    && r.continuous && quad_word == RESET_PATTERN |=> !r.continuous && r.phase == PH_IGNORE)
    else $error("reset pattern ignored");
  AST_NO_QPI: assert property (rise && r.phase == PH_CMD && r.cnt == CMD_LAST
    && cmd_byte == OP_QPI_ENTER |=> r.phase == PH_IGNORE) else $error("all-quad mode entered");

  // register bus
  AST_AVM_ANSWER: assert property ((avm_req.read || avm_req.write) && !r.ack |=> !avm_waitrequest)
    else $error("bus not answered after one wait cycle");
  AST_AVM_PULSE: assert property (r.ack |=> !r.ack) else $error("bus answer held too long");

  COV_CONTINUOUS: cover property ($rose(r.continuous));
  COV_WAKE: cover property ($fell(waking));
  COV_PARAM_READ: cover property (fall && r.phase == PH_POUT);
  COV_STATUS_WRITE: cover property (cs_rise && r.phase == PH_WRSR && r.cnt == WRSR_DONE);
  COV_RESET_PATTERN: cover property (rise && r.phase == PH_QADDR && r.cnt == QADDR_LAST && quad_word == RESET_PATTERN);
endmodule
